// file: src/asp_cfg.svh
// Register map, field positions, reset values and counts of the serial port
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH

`define ASP_OFS_STATUS 8'h25
`define ASP_OFS_FRAME 8'h26
`define ASP_OFS_FILTER 8'h27
`define ASP_OFS_RXBUF 8'h28
`define ASP_OFS_TXBUF 8'h29

`define ASP_FRM_TXE 7
`define ASP_FRM_RXE 6
`define ASP_FRM_TX_STOP_LENGTH_SELECT 5
`define ASP_FRM_EVEN 4
`define ASP_FRM_PE 3
`define ASP_FRM_BRG_HI 2
`define ASP_FRM_BRG_LO 0
`define ASP_FLT_SEL_HI 2
`define ASP_FLT_SEL_LO 1
`define ASP_FLT_STOPR 0

`define ASP_ST_PARITY_ERROR_FLAG 7
`define ASP_ST_FRAMING_ERROR_FLAG 6
`define ASP_ST_OERR 5
`define ASP_ST_RBFL 4
`define ASP_ST_TX_DONE_FLAG 3
`define ASP_ST_TX_BUFFER_EMPTY_FLAG 2

`define ASP_FRAME_RST 8'h00
`define ASP_FILTER_RST 8'h00
`define ASP_STATUS_RST 8'h0C

`define ASP_BRG_DIV13 3'h0
`define ASP_BRG_DIV26 3'h1
`define ASP_BRG_DIV52 3'h2
`define ASP_BRG_DIV104 3'h3
`define ASP_BRG_DIV208 3'h4
`define ASP_BRG_DIV416 3'h5
`define ASP_BRG_TIMER3 3'h6
`define ASP_BRG_DIV96 3'h7
`define ASP_DIV13 9'h00D
`define ASP_DIV26 9'h01A
`define ASP_DIV52 9'h034
`define ASP_DIV104 9'h068
`define ASP_DIV208 9'h0D0
`define ASP_DIV416 9'h1A0
`define ASP_DIV96 9'h060

`define ASP_FLT_REJ1 7'h1F
`define ASP_FLT_REJ2 7'h3F
`define ASP_FLT_REJ3 7'h7F

`define ASP_RT_S0 4'h7
`define ASP_RT_S1 4'h8
`define ASP_RT_S2 4'h9
`define ASP_RT_LAST 4'hF
`define ASP_LAST_BIT 3'h7

`endif

// file: src/asp_pkg.sv
// Types shared by the serial port modules
package asp_pkg;

    typedef enum logic [2:0] {
        ASP_IDLE = 3'b000,
        ASP_START = 3'b001,
        ASP_DATA = 3'b010,
        ASP_PARITY = 3'b011,
        ASP_STOP1 = 3'b100,
        ASP_STOP2 = 3'b101
    } asp_phase_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic level;
        logic [6:0] cnt;
    } asp_filt_t;

    typedef struct packed {
        logic [7:0] frame;
        logic [7:0] filter;
        logic [7:0] rdata;
        logic txd;
        logic tx_int;
        logic [8:0] div_cnt;
        logic rt_tick;
        logic tx_buffer_empty_flag;
        logic tx_done_flag;
        logic tx_armed;
        logic rx_armed;
        logic [7:0] txbuf;
        asp_phase_t tx_ph;
        logic [3:0] tx_rt;
        logic [2:0] tx_bit;
        logic [7:0] tx_data;
        asp_phase_t rx_ph;
        logic [3:0] rx_rt;
        logic [2:0] rx_bit;
        logic [1:0] rx_samp;
        logic [7:0] rx_sh;
        logic rx_parity_error_flag;
        logic rx_framing_error_flag;
        logic [7:0] rxbuf;
        logic parity_error_flag;
        logic framing_error_flag;
        logic oerr;
        logic rbfl;
    } asp_state_t;

endpackage

// file: src/asp_noise_filter.sv
// Receive pin synchroniser and selectable glitch filter
`timescale 1ns/1ns
`default_nettype none
`include "asp_cfg.svh"

module asp_noise_filter
    import asp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic pin_i,
    input wire logic [1:0] sel_i,
    output logic level_o
);

    asp_filt_t st_reg;
    asp_filt_t st_next;
    logic [6:0] limit;

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = pin_i;
        st_next.sync2 = st_reg.sync1;
        case (sel_i)
            2'h1: limit = `ASP_FLT_REJ1;
            2'h2: limit = `ASP_FLT_REJ2;
            default: limit = `ASP_FLT_REJ3;
        endcase
        if (sel_i == 2'h0) begin
            // No rejection: level follows the synchronised pin
            st_next.level = st_reg.sync2;
            st_next.cnt = 7'h00;
        end else if (st_reg.sync2 == st_reg.level) begin
            st_next.cnt = 7'h00;
        end else if (st_reg.cnt + 7'h01 >= limit) begin
            // Pulse lasted the full rejection time, so it is real
            st_next.level = st_reg.sync2;
            st_next.cnt = 7'h00;
        end else begin
            st_next.cnt = st_reg.cnt + 7'h01;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_reg <= '{sync1: 1'b1, sync2: 1'b1, level: 1'b1, cnt: 7'h00};
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_o = st_reg.level;

endmodule
`default_nettype wire

// file: src/asp_serial_port.sv
// Asynchronous serial port: registers, baud source, transmitter, receiver
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "asp_cfg.svh"

module asp_serial_port
    import asp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic rxd_i,
    input wire logic timer3_match_event_i,
    output logic txd_o,
    output logic tx_interrupt_o
);

    asp_state_t st_reg;
    asp_state_t st_next;
    logic rx_level;
    logic [8:0] div_lim;
    logic [2:0] baud_source_select;
    logic maj;
    logic exp_par;
    logic rx_finish;
    logic rx_load;
    logic rx_overrun;
    logic tx_launch;

    asp_noise_filter u_filter (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .pin_i(rxd_i),
        .sel_i(st_reg.filter[`ASP_FLT_SEL_HI:`ASP_FLT_SEL_LO]),
        .level_o(rx_level)
    );

    // Parity bit for a byte; odd type makes the total count of ones odd
    function automatic logic par_bit(input logic [7:0] d, input logic even);
        par_bit = even ? (^d) : ~(^d);
    endfunction

    always_comb begin
        st_next = st_reg;
        baud_source_select = st_reg.frame[`ASP_FRM_BRG_HI:`ASP_FRM_BRG_LO];
        st_next.rdata = 8'h00;
        st_next.tx_int = 1'b0;
        rx_finish = 1'b0;
        rx_load = 1'b0;
        rx_overrun = 1'b0;
        tx_launch = 1'b0;
        maj = 1'b0;
        exp_par = 1'b0;

        // Register bus
        if (rd_i) begin
            case (addr_i)
                `ASP_OFS_STATUS: begin
                    st_next.rdata = {st_reg.parity_error_flag, st_reg.framing_error_flag, st_reg.oerr,
                        st_reg.rbfl, st_reg.tx_done_flag, st_reg.tx_buffer_empty_flag, 2'h0};
                    st_next.tx_armed = 1'b1;
                    st_next.rx_armed = 1'b1;
                end
                `ASP_OFS_RXBUF: begin
                    st_next.rdata = st_reg.rxbuf;
                    if (st_reg.rx_armed) begin
                        st_next.parity_error_flag = 1'b0;
                        st_next.framing_error_flag = 1'b0;
                        st_next.oerr = 1'b0;
                        st_next.rbfl = 1'b0;
                        st_next.rx_armed = 1'b0;
                    end
                end
                default: st_next.rdata = 8'h00;
            endcase
        end
        if (wr_i) begin
            case (addr_i)
                `ASP_OFS_FRAME: begin
                    st_next.frame = wdata_i;
                    // Stale byte is thrown away on re-enable
                    if (wdata_i[`ASP_FRM_TXE] && !st_reg.frame[`ASP_FRM_TXE]) begin
                        st_next.tx_buffer_empty_flag = 1'b1;
                    end
                end
                `ASP_OFS_FILTER: st_next.filter = wdata_i;
                `ASP_OFS_TXBUF: begin
                    st_next.txbuf = wdata_i;
                    // Without a status read first the write never starts a frame
                    if (st_reg.tx_armed) begin
                        st_next.tx_buffer_empty_flag = 1'b0;
                        st_next.tx_armed = 1'b0;
                    end
                end
                default: st_next.txbuf = st_reg.txbuf;
            endcase
        end

        // Shared 16x sample clock for both directions
        case (baud_source_select)
            `ASP_BRG_DIV13: div_lim = `ASP_DIV13;
            `ASP_BRG_DIV26: div_lim = `ASP_DIV26;
            `ASP_BRG_DIV52: div_lim = `ASP_DIV52;
            `ASP_BRG_DIV104: div_lim = `ASP_DIV104;
            `ASP_BRG_DIV208: div_lim = `ASP_DIV208;
            `ASP_BRG_DIV416: div_lim = `ASP_DIV416;
            default: div_lim = `ASP_DIV96;
        endcase
        if (baud_source_select == `ASP_BRG_TIMER3) begin
            st_next.rt_tick = timer3_match_event_i;
            st_next.div_cnt = 9'h000;
        end else if (st_reg.div_cnt >= div_lim - 9'h001) begin
            // >= so a shorter divisor picked mid-count still wraps
            st_next.rt_tick = 1'b1;
            st_next.div_cnt = 9'h000;
        end else begin
            st_next.rt_tick = 1'b0;
            st_next.div_cnt = st_reg.div_cnt + 9'h001;
        end

        // Transmitter
        if (st_reg.tx_ph == ASP_IDLE) begin
            // Enable is looked at only between frames
            if (st_reg.frame[`ASP_FRM_TXE] && !st_reg.tx_buffer_empty_flag) begin
                tx_launch = 1'b1;
                st_next.tx_ph = ASP_START;
                st_next.tx_rt = 4'h0;
                st_next.tx_data = st_reg.txbuf;
                st_next.tx_buffer_empty_flag = 1'b1;
                st_next.tx_done_flag = 1'b0;
                st_next.tx_int = 1'b1;
            end
        end else if (st_reg.rt_tick) begin
            st_next.tx_rt = st_reg.tx_rt + 4'h1;
            if (st_reg.tx_rt == `ASP_RT_LAST) begin
                case (st_reg.tx_ph)
                    ASP_START: begin
                        st_next.tx_ph = ASP_DATA;
                        st_next.tx_bit = 3'h0;
                    end
                    ASP_DATA: begin
                        st_next.tx_bit = st_reg.tx_bit + 3'h1;
                        if (st_reg.tx_bit == `ASP_LAST_BIT) begin
                            st_next.tx_ph = st_reg.frame[`ASP_FRM_PE] ?
                                ASP_PARITY : ASP_STOP1;
                        end
                    end
                    ASP_PARITY: st_next.tx_ph = ASP_STOP1;
                    ASP_STOP1: begin
                        st_next.tx_ph = st_reg.frame[`ASP_FRM_TX_STOP_LENGTH_SELECT] ?
                            ASP_STOP2 : ASP_IDLE;
                        if (!st_reg.frame[`ASP_FRM_TX_STOP_LENGTH_SELECT] && st_next.tx_buffer_empty_flag) begin
                            st_next.tx_done_flag = 1'b1;
                        end
                    end
                    ASP_STOP2: begin
                        st_next.tx_ph = ASP_IDLE;
                        if (st_next.tx_buffer_empty_flag) begin
                            st_next.tx_done_flag = 1'b1;
                        end
                    end
                    default: st_next.tx_ph = ASP_IDLE;
                endcase
            end
        end
        case (st_next.tx_ph)
            ASP_START: st_next.txd = 1'b0;
            ASP_DATA: st_next.txd = st_next.tx_data[st_next.tx_bit];
            ASP_PARITY: st_next.txd = par_bit(st_next.tx_data,
                st_reg.frame[`ASP_FRM_EVEN]);
            default: st_next.txd = 1'b1;
        endcase

        // Receiver
        maj = (st_reg.rx_samp[0] & st_reg.rx_samp[1]) |
            (st_reg.rx_samp[0] & rx_level) |
            (st_reg.rx_samp[1] & rx_level);
        exp_par = par_bit(st_reg.rx_sh, st_reg.frame[`ASP_FRM_EVEN]);
        if (st_reg.rt_tick) begin
            if (st_reg.rx_ph == ASP_IDLE) begin
                // Overrun holds off reception until it is cleared
                if (st_reg.frame[`ASP_FRM_RXE] && !st_reg.oerr && !rx_level) begin
                    st_next.rx_ph = ASP_START;
                    st_next.rx_rt = 4'h0;
                    st_next.rx_parity_error_flag = 1'b0;
                    st_next.rx_framing_error_flag = 1'b0;
                end
            end else begin
                st_next.rx_rt = st_reg.rx_rt + 4'h1;
                if (st_reg.rx_rt == `ASP_RT_S0) begin
                    st_next.rx_samp[0] = rx_level;
                end
                if (st_reg.rx_rt == `ASP_RT_S1) begin
                    st_next.rx_samp[1] = rx_level;
                end
                if (st_reg.rx_rt == `ASP_RT_S2) begin
                    case (st_reg.rx_ph)
                        ASP_START: begin
                            st_next.rx_ph = maj ? ASP_IDLE : ASP_DATA;
                            st_next.rx_bit = 3'h0;
                        end
                        ASP_DATA: begin
                            st_next.rx_sh = {maj, st_reg.rx_sh[7:1]};
                            st_next.rx_bit = st_reg.rx_bit + 3'h1;
                            if (st_reg.rx_bit == `ASP_LAST_BIT) begin
                                st_next.rx_ph = st_reg.frame[`ASP_FRM_PE] ?
                                    ASP_PARITY : ASP_STOP1;
                            end
                        end
                        ASP_PARITY: begin
                            st_next.rx_parity_error_flag = (maj != exp_par);
                            st_next.rx_ph = ASP_STOP1;
                        end
                        ASP_STOP1: begin
                            st_next.rx_framing_error_flag = !maj;
                            if (st_reg.filter[`ASP_FLT_STOPR] && maj) begin
                                st_next.rx_ph = ASP_STOP2;
                            end else begin
                                rx_finish = 1'b1;
                            end
                        end
                        ASP_STOP2: begin
                            st_next.rx_framing_error_flag = !maj;
                            rx_finish = 1'b1;
                        end
                        default: st_next.rx_ph = ASP_IDLE;
                    endcase
                end
            end
        end
        if (rx_finish) begin
            st_next.rx_ph = ASP_IDLE;
            // Set wins over a clear in the same cycle
            if (st_reg.rbfl) begin
                rx_overrun = 1'b1;
                st_next.oerr = 1'b1;
            end else begin
                rx_load = 1'b1;
                st_next.rxbuf = st_reg.rx_sh;
                st_next.rbfl = 1'b1;
                st_next.parity_error_flag = st_next.rx_parity_error_flag;
                st_next.framing_error_flag = st_next.rx_framing_error_flag;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_reg <= '0;
            st_reg.frame <= `ASP_FRAME_RST;
            st_reg.filter <= `ASP_FILTER_RST;
            st_reg.txd <= 1'b1;
            st_reg.tx_buffer_empty_flag <= 1'b1;
            st_reg.tx_done_flag <= 1'b1;
            st_reg.tx_ph <= ASP_IDLE;
            st_reg.rx_ph <= ASP_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.rdata;
    assign txd_o = st_reg.txd;
    assign tx_interrupt_o = st_reg.tx_int;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    a_tx_idle_high: assert property (st_reg.tx_ph == ASP_IDLE |-> txd_o)
        else $error("tx line low while idle");
    a_tx_start_low: assert property (st_reg.tx_ph == ASP_START |-> !txd_o)
        else $error("start bit not low");
    a_tx_parity_bit: assert property (st_reg.tx_ph == ASP_PARITY |->
        txd_o == par_bit(st_reg.tx_data, st_reg.frame[`ASP_FRM_EVEN]))
        else $error("wrong parity bit");
    a_tx_buffer_empty_flag_on_int: assert property (tx_interrupt_o |-> st_reg.tx_buffer_empty_flag)
        else $error("interrupt without empty flag");
    a_tx_buffer_empty_flag_write_clr: assert property (
        wr_i && addr_i == `ASP_OFS_TXBUF && st_reg.tx_armed && st_reg.tx_buffer_empty_flag
        |=> !st_reg.tx_buffer_empty_flag ##1 st_reg.tx_buffer_empty_flag ==
            $past(st_reg.frame[`ASP_FRM_TXE] && st_reg.tx_ph == ASP_IDLE))
        else $error("empty flag not cleared by write");
    a_overrun_keeps: assert property (rx_overrun |=>
        $stable(st_reg.rxbuf) && st_reg.oerr)
        else $error("overrun changed receive buffer");
    a_rx_flags_clr: assert property (
        rd_i && addr_i == `ASP_OFS_RXBUF && st_reg.rx_armed && !rx_load
        |=> !st_reg.rbfl && !st_reg.parity_error_flag && !st_reg.framing_error_flag)
        else $error("receive flags not cleared");
    a_baud_div13: assert property (
        st_reg.rt_tick && baud_source_select == `ASP_BRG_DIV13 && !wr_i
        |=> !st_reg.rt_tick [*8] ##5 st_reg.rt_tick)
        else $error("fc/13 tick spacing wrong");
    a_tx_stop_len: assert property (st_reg.tx_ph == ASP_STOP2 |->
        st_reg.frame[`ASP_FRM_TX_STOP_LENGTH_SELECT])
        else $error("second stop bit not selected");

    c_tx_frame: cover property (tx_launch);
    c_rx_load: cover property (rx_load);
    c_overrun: cover property (rx_overrun);
    c_parity_err: cover property (rx_load && st_next.rx_parity_error_flag);

endmodule
`default_nettype wire

// file: tb/asp_peer_model.sv
// Remote serial peer: frame sender and frame monitor on the device pins
`timescale 1ns/1ns
`default_nettype none

module asp_peer_model (
    input wire logic mclk_i,
    input wire logic txd_i,
    input wire logic mon_en_i,
    input wire logic par_en_i,
    input wire logic [15:0] bit_cyc_i,
    output logic rxd_o
);
    // Each entry holds {stop, parity, data} as seen on the line
    logic [9:0] got_q[$];
    logic [9:0] rx_f;

    initial begin
        rxd_o = 1'h1;
    end

    // Mid-bit sampling from the start edge; stop 2 is left to the bench
    always begin
        @(negedge txd_i iff mon_en_i === 1'h1);
        rx_f = 10'h000;
        repeat (bit_cyc_i / 2) @(posedge mclk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc_i) @(posedge mclk_i);
            rx_f[i] = txd_i;
        end
        if (par_en_i) begin
            repeat (bit_cyc_i) @(posedge mclk_i);
            rx_f[8] = txd_i;
        end
        repeat (bit_cyc_i) @(posedge mclk_i);
        rx_f[9] = txd_i;
        got_q.push_back(rx_f);
    end

    task automatic drive_bit(input logic b);
        rxd_o <= b;
        repeat (bit_cyc_i) @(posedge mclk_i);
    endtask

    task automatic send_frame(input logic [7:0] d, input logic pe,
        input logic ev, input logic flip, input int stops, input logic sv);
        drive_bit(1'h0);
        for (int i = 0; i < 8; i++) begin
            drive_bit(d[i]);
        end
        if (pe) begin
            drive_bit(^d ^ ~ev ^ flip);
        end
        drive_bit(sv);
        if (stops == 2) begin
            drive_bit(1'h1);
        end
        rxd_o <= 1'h1;
    endtask

    task automatic glitch(input int len);
        rxd_o <= 1'h0;
        repeat (len) @(posedge mclk_i);
        rxd_o <= 1'h1;
    endtask
endmodule

`default_nettype wire

// file: tb/tb_asp_serial_port.sv
// Self-checking bench: registers, transmit, receive and noise filter
`timescale 1ns/1ns
`default_nettype none
`include "asp_cfg.svh"

module tb_asp_serial_port;
    logic mclk, rst_n, wr, rd, rxd, t3_evt, txd, tx_int, mon_en, par_en;
    logic int_seen, ok;
    logic [7:0] addr, wdata, rdata, v;
    logic [15:0] bit_cyc;
    int fail_count, checks_done, cyc, t3_cnt, n, t0, t1;
    int divs[8] = '{13, 26, 52, 104, 208, 416, 7, 96};
    logic [7:0] cd[5] = '{8'h5A, 8'hC3, 8'h81, 8'h7E, 8'h11};
    logic [7:0] cf[5] = '{8'h48, 8'h58, 8'h58, 8'h40, 8'h40};
    logic [7:0] cs[5] = '{8'h1C, 8'h1C, 8'h9C, 8'h5C, 8'h3C};

    asp_serial_port asp_serial_port_inst (.mclk_i(mclk), .rstn_i(rst_n),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .rxd_i(rxd), .timer3_match_event_i(t3_evt),
        .txd_o(txd), .tx_interrupt_o(tx_int));

    asp_peer_model asp_peer_model_inst (.mclk_i(mclk), .txd_i(txd),
        .mon_en_i(mon_en), .par_en_i(par_en), .bit_cyc_i(bit_cyc),
        .rxd_o(rxd));

    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end

    // Timer 3 match every 7 clocks, free running
    always @(posedge mclk) begin
        t3_cnt <= (t3_cnt == 6) ? 0 : t3_cnt + 1;
        t3_evt <= (t3_cnt == 6);
        cyc <= cyc + 1;
        if (tx_int === 1'h1) int_seen <= 1'h1;
        if (cyc == 95000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] e,
        input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, e, g);
        end
    endtask

    task automatic step();
        @(posedge mclk);
        #1;
    endtask

    // Strobes drop on the edge that takes them, so calls may abut
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge mclk);
        wr <= 1'h0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'h1;
        @(posedge mclk);
        rd <= 1'h0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
        input string what);
        rd_reg(a, v);
        chk(what, e, v);
    endtask

    task automatic tx_byte(input logic [7:0] d);
        rd_reg(`ASP_OFS_STATUS, v);
        chk("empty before write", 1, v[`ASP_ST_TX_BUFFER_EMPTY_FLAG]);
        wr_reg(`ASP_OFS_TXBUF, d);
    endtask

    task automatic wait_lvl(input logic lv, input int lim);
        n = 0;
        while (txd !== lv && n < lim) begin
            step();
            n++;
        end
        chk("txd wait", 1, n < lim);
    endtask

    task automatic wait_int(input int lim);
        n = 0;
        while (tx_int !== 1'h1 && n < lim) begin
            step();
            n++;
        end
        chk("interrupt wait", 1, n < lim);
    endtask

    task automatic wait_got(input int cnt);
        n = 0;
        while (asp_peer_model_inst.got_q.size() < cnt && n < 6000) begin
            step();
            n++;
        end
        chk("frame wait", 1, n < 6000);
    endtask

    task automatic do_reset();
        rst_n <= 1'h0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'h1;
        step();
    endtask

    function automatic logic [9:0] exp_fr(input logic [7:0] d,
        input logic pe, input logic ev);
        return {1'h1, pe & (^d ^ ~ev), d};
    endfunction

    initial begin
        {rst_n, wr, rd, mon_en, par_en, int_seen} = 6'h00;
        {addr, wdata} = 16'h0000;
        bit_cyc = 16'h00D0;
        fail_count = 0;
        checks_done = 0;
        do_reset();
        rd_chk(`ASP_OFS_STATUS, 8'h0C, "status reset");
        wr_reg(`ASP_OFS_STATUS, 8'hF3);
        rd_chk(`ASP_OFS_STATUS, 8'h0C, "status read only");
        rd_chk(`ASP_OFS_FRAME, 8'h00, "frame write only");
        wr_reg(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00, "unmapped");
        chk("txd idle", 1, txd);
        $display("test registers done");

        // Second reset cuts each frame short after its start bit
        for (int s = 0; s < 8; s++) begin
            do_reset();
            wr_reg(`ASP_OFS_FRAME, 8'h80 | s[7:0]);
            int_seen <= 1'h0;
            tx_byte(8'h01);
            wait_lvl(1'h0, 10);
            wait_lvl(1'h1, 8000);
            ok = n <= 16 * divs[s] + 1 && n >= 15 * divs[s];
            chk("start width", 1, ok);
            rd_chk(`ASP_OFS_STATUS, 8'h04, "status sending");
            chk("tx interrupt", 1, int_seen);
        end
        $display("test baud select done");

        do_reset();
        mon_en <= 1'h1;
        for (int f = 0; f < 4; f++) begin
            par_en <= f[0];
            wr_reg(`ASP_OFS_FRAME, {2'h2, f[1], f[1] ^ f[0], f[0], 3'h0});
            tx_byte(8'hA5 + f[7:0]);
            wait_int(20);
            t1 = cyc;
            tx_byte(8'h3C ^ f[7:0]);
            rd_chk(`ASP_OFS_STATUS, 8'h00, "status queued");
            wait_int(4000);
            t0 = (10 + f[0] + f[1]) * 208;
            // One idle cycle separates the last stop from the next start
            ok = cyc - t1 <= t0 + 1 && cyc - t1 >= t0 - 13;
            chk("frame length", 1, ok);
            wait_got(2);
            repeat (416) step();
            chk("frame a", exp_fr(8'hA5 + f[7:0], f[0], f[1] ^ f[0]),
                asp_peer_model_inst.got_q[0]);
            chk("frame b", exp_fr(8'h3C ^ f[7:0], f[0], f[1] ^ f[0]),
                asp_peer_model_inst.got_q[1]);
            asp_peer_model_inst.got_q.delete();
            rd_chk(`ASP_OFS_STATUS, 8'h0C, "status end");
            chk("txd idle", 1, txd);
        end
        $display("test transmit format done");

        do_reset();
        wr_reg(`ASP_OFS_FRAME, 8'h80);
        wr_reg(`ASP_OFS_TXBUF, 8'h55);
        repeat (40) step();
        chk("txd unread status", 1, txd);
        rd_chk(`ASP_OFS_STATUS, 8'h0C, "status unarmed");
        wr_reg(`ASP_OFS_FRAME, 8'h00);
        tx_byte(8'h55);
        rd_chk(`ASP_OFS_STATUS, 8'h08, "status full");
        wr_reg(`ASP_OFS_FRAME, 8'h80);
        repeat (40) step();
        chk("txd stale", 1, txd);
        rd_chk(`ASP_OFS_STATUS, 8'h0C, "status reenable");
        par_en <= 1'h0;
        tx_byte(8'h96);
        wait_int(20);
        repeat (300) step();
        wr_reg(`ASP_OFS_FRAME, 8'h00);
        wait_got(1);
        chk("drained frame", 10'h296, asp_peer_model_inst.got_q[0]);
        $display("test transmit enable done");

        do_reset();
        for (int i = 0; i < 5; i++) begin
            wr_reg(`ASP_OFS_FRAME, cf[i]);
            wr_reg(`ASP_OFS_FILTER, {7'h00, i == 1});
            asp_peer_model_inst.send_frame(cd[i], cf[i][3], cf[i][4],
                i == 2, (i == 1) ? 2 : 1, i != 3);
            if (i == 4)
                asp_peer_model_inst.send_frame(8'h22, 0, 0, 0, 1, 1);
            repeat (150) step();
            rd_chk(`ASP_OFS_STATUS, cs[i], "rx status");
            rd_chk(`ASP_OFS_RXBUF, cd[i], "rx data");
            rd_chk(`ASP_OFS_STATUS, 8'h0C, "rx cleared");
        end
        $display("test receive done");

        for (int s = 1; s < 4; s++) begin
            wr_reg(`ASP_OFS_FILTER, s[7:0] << 1);
            asp_peer_model_inst.glitch((32 << (s - 1)) - 2);
            // Majority voting would hide a passed glitch, so watch the filter
            ok = 1'h0;
            repeat (600) begin
                step();
                if (asp_serial_port_inst.rx_level !== 1'h1) ok = 1'h1;
            end
            chk("glitch level", 0, ok);
            rd_chk(`ASP_OFS_STATUS, 8'h0C, "glitch dropped");
        end
        asp_peer_model_inst.send_frame(8'hF0, 0, 0, 0, 1, 1);
        repeat (200) step();
        rd_chk(`ASP_OFS_STATUS, 8'h1C, "filtered status");
        rd_chk(`ASP_OFS_RXBUF, 8'hF0, "filtered data");
        $display("test noise filter done");
        final_report();
    end
endmodule

`default_nettype wire
